// ---- rtl/gitp_pkg.sv ----
package gitp_pkg;
   // ************************************************************
   // widths and depths
   // ************************************************************
   localparam int WORD_W = 16;
   localparam int PIX_W = 8;
   localparam int COORD_W = 12;
   localparam int FIFO_DEPTH = 8;
   localparam int LVL_W = 4;
   // level above which fewer than four slots are free
   localparam logic [LVL_W-1:0] QFEW_LEVEL = 4'h4;

   // ************************************************************
   // command word fields
   // ************************************************************
   localparam int CMD_OP_HI = 15;
   localparam int CMD_OP_LO = 13;
   localparam logic [2:0] OP_RECT = 3'h2;
   localparam int CMD_SWAP = 12;
   localparam int CMD_BUS16 = 9;
   localparam int CMD_WAIT = 8;
   localparam int CMD_XMAJ = 6;
   localparam int CMD_XPOS = 5;
   localparam int CMD_DRAW = 4;
   localparam int CMD_MULTI = 1;
   localparam int CMD_WRITE = 0;
   localparam logic [15:0] RST_CMD = 16'h0001;

   // ************************************************************
   // multifunction control and mix select fields
   // ************************************************************
   localparam int MC_SEL_HI = 7;
   localparam int MC_SEL_LO = 6;
   localparam logic [1:0] MC_SEL_FORE = 2'h0;
   localparam logic [1:0] MC_SEL_HOST = 2'h2;
   localparam logic [1:0] MC_SEL_VMEM = 2'h3;
   localparam int MIX_SRC_HI = 6;
   localparam int MIX_SRC_LO = 5;
   localparam logic [1:0] SRC_BACK = 2'h0;
   localparam logic [1:0] SRC_FORE = 2'h1;
   localparam logic [1:0] SRC_HOST = 2'h2;
   localparam logic [3:0] MIX_ZERO = 4'h1;
   localparam logic [3:0] MIX_ONE = 4'h2;
   localparam logic [3:0] MIX_NEW = 4'h7;

   // ************************************************************
   // status word bits and unit widths
   // ************************************************************
   localparam int STAT_QFEW = 4;
   localparam int STAT_AVAIL = 8;
   localparam int STAT_BUSY = 9;
   localparam logic [15:0] RST_STATUS = 16'h0000;
   localparam logic [4:0] UW_MONO = 5'h01;
   localparam logic [4:0] UW_NIB = 5'h04;
   localparam logic [4:0] UW_BYTE = 5'h08;
   localparam logic [4:0] UW_WORD = 5'h10;

   typedef enum logic [2:0] {
      ST_IDLE, ST_FETCH, ST_WPIX, ST_RREQ, ST_RWAIT, ST_RPUSH
   } gitp_state_e;
endpackage

// ---- rtl/gitp_fifo_if.sv ----
`timescale 1ns/100ps
interface gitp_fifo_if;
   import gitp_pkg::*;
   logic in_valid;
   logic in_ready;
   logic [WORD_W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [WORD_W-1:0] out_data;
   logic [LVL_W-1:0] level;
   modport fill (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data, level);
   modport store (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data, level);
endinterface // gitp_fifo_if

// ---- rtl/gitp_fifo.sv ----
`timescale 1ns/100ps
module gitp_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   gitp_fifo_if.store f
);
   import gitp_pkg::*;
   localparam int AW = $clog2(D);

   logic [W-1:0] mem_q [D];
   logic [W-1:0] mem_d [D];
   logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
   logic [LVL_W-1:0] cnt_q, cnt_d;
   logic do_push, do_pop;

   // ************************************************************
   // pointers and storage
   // ************************************************************
   always_comb begin
      do_push = f.in_valid && (cnt_q != LVL_W'(D));
      do_pop = f.out_ready && (cnt_q != '0);
      mem_d = mem_q;
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      if (do_push) begin
         mem_d[wptr_q] = f.in_data;
         wptr_d = AW'(wptr_q + 1'b1);
      end
      if (do_pop) begin
         rptr_d = AW'(rptr_q + 1'b1);
      end
      cnt_d = LVL_W'(cnt_q + LVL_W'(do_push) - LVL_W'(do_pop));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
         for (int i = 0; i < D; i++) begin
            mem_q[i] <= '0;
         end
      end else begin
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q <= cnt_d;
         mem_q <= mem_d;
      end
   end

   // full and empty straight from the count register
   assign f.in_ready = (cnt_q != LVL_W'(D));
   assign f.out_valid = (cnt_q != '0);
   assign f.out_data = mem_q[rptr_q];
   assign f.level = cnt_q;

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_fifo_no_over: assert property (cnt_q <= LVL_W'(D))
      else $error("fifo count beyond depth");
endmodule // gitp_fifo

// ---- rtl/gitp_top.sv ----
`timescale 1ns/100ps
// What this block does
// - word writes: byte per pixel, pad rows
// - four-bit pixels: two per byte, pad
// - eight-bit command: byte or half-width bytes
// - mono write: eight pixels per byte, pad
// - host bit picks fore or back mix
// - byte transfers pad mono rows to eight
// - logical one/zero mixes, write mask gates
// - colour source: host, fore or back
// - command word fields steer the transfer
// - status bit 8 flags data available
// - word reads: byte per pixel, pad rows
// - four-bit reads: nibble pairs, padded rows
// - mono reads padded to sixteen bits, or eight on byte transfers
// - read mask ands enabled planes together
// - memory data select mode uses the fore mix alone
// - fore select mode: fore mix alone colours every pixel
// - status bit 4 says few free slots
module gitp_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [gitp_pkg::WORD_W-1:0] cmd_word,
   input wire logic cmd_wr,
   input wire logic [gitp_pkg::WORD_W-1:0] multi_control,
   input wire logic [gitp_pkg::WORD_W-1:0] fore_mix_select,
   input wire logic [gitp_pkg::WORD_W-1:0] back_mix_select,
   input wire logic [gitp_pkg::PIX_W-1:0] fore_colour,
   input wire logic [gitp_pkg::PIX_W-1:0] back_colour,
   input wire logic [gitp_pkg::PIX_W-1:0] plane_write_mask,
   input wire logic [gitp_pkg::PIX_W-1:0] plane_read_mask,
   input wire logic four_plane,
   input wire logic [gitp_pkg::COORD_W-1:0] start_x,
   input wire logic [gitp_pkg::COORD_W-1:0] start_y,
   input wire logic [gitp_pkg::COORD_W-1:0] rect_width_minus_one,
   input wire logic [gitp_pkg::COORD_W-1:0] rect_height_minus_one,
   input wire logic [gitp_pkg::WORD_W-1:0] pixel_data_port_wr,
   input wire logic pixel_data_port_wr_valid,
   output logic pixel_data_port_wr_ready,
   input wire logic pixel_data_port_rd_strobe,
   output logic [gitp_pkg::WORD_W-1:0] pixel_data_port_rd,
   output logic [gitp_pkg::WORD_W-1:0] gp_status,
   output logic [gitp_pkg::COORD_W-1:0] vm_x,
   output logic [gitp_pkg::COORD_W-1:0] vm_y,
   output logic vm_we,
   output logic [gitp_pkg::PIX_W-1:0] vm_wdata,
   output logic [gitp_pkg::PIX_W-1:0] vm_wmask,
   output logic vm_re,
   input wire logic vm_rvalid,
   input wire logic [gitp_pkg::PIX_W-1:0] vm_rdata
);
   import gitp_pkg::*;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [4:0] unit_w(input logic across, input logic nib);
      unit_w = across ? UW_MONO : (nib ? UW_NIB : UW_BYTE);
   endfunction

   function automatic logic [15:0] order_word(input logic [15:0] w, input logic swap);
      order_word = swap ? {w[7:0], w[15:8]} : w;
   endfunction

   function automatic logic [7:0] apply_mix(input logic [3:0] code, input logic [7:0] c);
      unique case (code)
         MIX_ZERO: apply_mix = 8'h00;
         MIX_ONE: apply_mix = 8'hff;
         default: apply_mix = c;
      endcase
   endfunction

   gitp_state_e state_q, state_d;
   logic [15:0] cmd_q, cmd_d, sh_q, sh_d, acc_q, acc_d, status_q, status_d;
   logic [15:0] rd_q, rd_d;
   logic [COORD_W-1:0] x_q, x_d, y_q, y_d, col_q, col_d, row_q, row_d;
   logic [COORD_W-1:0] w_q, w_d, h_q, h_d, x0_q, x0_d;
   logic [4:0] left_q, left_d, fill_q, fill_d;
   logic last_q, last_d;
   logic [COORD_W-1:0] vx_q, vx_d, vy_q, vy_d;
   logic [7:0] wd_q, wd_d, wm_q, wm_d;
   logic we_q, we_d, re_q, re_d;
   logic read_q, across, nib, bus16, swap, cmd_ok, row_end, last_px, pop, push;
   logic sel_bg;
   logic [4:0] uw, tw;
   logic [7:0] src_pix, rd_unit, wr_colour;
   logic [15:0] mixsel, push_word;
   logic rdy_q, rdy_d;
   logic [LVL_W-1:0] lvl_next;

   gitp_fifo_if f ();
   gitp_fifo #(.W(WORD_W), .D(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .f(f)
   );

   // ************************************************************
   // decode of latched command
   // ************************************************************
   // command field decode
   assign read_q = !cmd_q[CMD_WRITE];
   assign across = cmd_q[CMD_MULTI];
   assign bus16 = cmd_q[CMD_BUS16];
   assign swap = cmd_q[CMD_SWAP];
   // four-plane packs two pixels per byte
   assign nib = four_plane && !across;
   assign uw = unit_w(across, nib);
   assign tw = bus16 ? UW_WORD : UW_BYTE;
   assign cmd_ok = cmd_wr && (state_q == ST_IDLE) && cmd_word[CMD_DRAW]
                   && (cmd_word[CMD_OP_HI:CMD_OP_LO] == OP_RECT);
   assign row_end = (col_q == w_q);
   assign last_px = row_end && (row_q == h_q);

   // ************************************************************
   // pixel colour on writes
   // ************************************************************
   // mono bit expands to a full pixel
   assign src_pix = across ? {8{sh_q[15]}} : (nib ? {4'h0, sh_q[15:12]} : sh_q[15:8]);
   // host bit zero picks the back mix
   assign sel_bg = (multi_control[MC_SEL_HI:MC_SEL_LO] == MC_SEL_HOST) && !sh_q[15];
   // fore select uses fore mix only
   assign mixsel = sel_bg ? back_mix_select : fore_mix_select;
   always_comb begin
      unique case (mixsel[MIX_SRC_HI:MIX_SRC_LO])
         SRC_BACK: wr_colour = back_colour;
         SRC_FORE: wr_colour = fore_colour;
         default: wr_colour = src_pix;
      endcase
      wr_colour = apply_mix(mixsel[3:0], wr_colour);
   end

   // ************************************************************
   // read data packing
   // ************************************************************
   // enabled read planes anded
   // memory bit is what selects on reads
   assign rd_unit = across ? {7'h0, &(vm_rdata | ~plane_read_mask)}
                           : (nib ? {4'h0, vm_rdata[3:0]} : vm_rdata);
   // earlier nibble ends in the upper half
   assign push_word = bus16 ? order_word(16'(acc_q << (UW_WORD - fill_q)), swap)
                            : {8'h00, 8'(acc_q << (UW_BYTE - fill_q))};

   // ************************************************************
   // engine
   // ************************************************************
   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      sh_d = sh_q;
      acc_d = acc_q;
      left_d = left_q;
      fill_d = fill_q;
      x_d = x_q;
      y_d = y_q;
      col_d = col_q;
      row_d = row_q;
      w_d = w_q;
      h_d = h_q;
      x0_d = x0_q;
      last_d = last_q;
      vx_d = vx_q;
      vy_d = vy_q;
      wd_d = wd_q;
      wm_d = wm_q;
      we_d = 1'b0;
      re_d = 1'b0;
      pop = 1'b0;
      push = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            if (cmd_ok) begin
               cmd_d = cmd_word;
               x_d = start_x;
               x0_d = start_x;
               y_d = start_y;
               w_d = rect_width_minus_one;
               h_d = rect_height_minus_one;
               col_d = '0;
               row_d = '0;
               acc_d = '0;
               fill_d = '0;
               last_d = 1'b0;
               state_d = cmd_word[CMD_WRITE] ? ST_FETCH : ST_RREQ;
            end
         end
         ST_FETCH: begin
            if (f.out_valid) begin
               pop = 1'b1;
               // swap puts the low byte first
               // byte transfers use the low byte only
               sh_d = bus16 ? order_word(f.out_data, swap) : {f.out_data[7:0], 8'h00};
               left_d = tw;
               state_d = ST_WPIX;
            end
         end
         ST_WPIX: begin
            we_d = 1'b1;
            vx_d = x_q;
            vy_d = y_q;
            wd_d = wr_colour;
            wm_d = plane_write_mask;
            sh_d = sh_q << uw;
            left_d = left_q - uw;
            // rest of the word at row end is padding
            // dummy nibbles dropped at row end
            if (row_end) begin
               state_d = last_px ? ST_IDLE : ST_FETCH;
            end else if (left_q == uw) begin
               state_d = ST_FETCH;
            end
         end
         ST_RREQ: begin
            re_d = 1'b1;
            vx_d = x_q;
            vy_d = y_q;
            state_d = ST_RWAIT;
         end
         ST_RWAIT: begin
            if (vm_rvalid) begin
               acc_d = (acc_q << uw) | {8'h00, rd_unit};
               fill_d = fill_q + uw;
               last_d = last_px;
               // row end closes the word early
               state_d = (row_end || (fill_q + uw == tw)) ? ST_RPUSH : ST_RREQ;
            end
         end
         ST_RPUSH: begin
            push = 1'b1;
            if (f.in_ready) begin
               acc_d = '0;
               fill_d = '0;
               state_d = last_q ? ST_IDLE : ST_RREQ;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // advance after each pixel, wrap per row
      if ((state_q == ST_WPIX) || ((state_q == ST_RWAIT) && vm_rvalid)) begin
         if (row_end) begin
            col_d = '0;
            x_d = x0_q;
            row_d = COORD_W'(row_q + 1'b1);
            y_d = COORD_W'(y_q + 1'b1);
         end else begin
            col_d = COORD_W'(col_q + 1'b1);
            x_d = COORD_W'(x_q + 1'b1);
         end
      end
   end

   // ************************************************************
   // host port and status
   // ************************************************************
   // one fifo serves both directions; the command picks which side fills it
   assign f.in_valid = read_q ? push : pixel_data_port_wr_valid;
   assign f.in_data = read_q ? push_word : pixel_data_port_wr;
   assign f.out_ready = read_q ? pixel_data_port_rd_strobe : pop;
   always_comb begin
      rd_d = rd_q;
      if (read_q && pixel_data_port_rd_strobe && f.out_valid) begin
         rd_d = f.out_data;
      end
      status_d = RST_STATUS;
      status_d[STAT_BUSY] = (state_q != ST_IDLE);
      // data available only when read data waits
      status_d[STAT_AVAIL] = read_q && f.out_valid;
      // host polls this before a group of writes
      status_d[STAT_QFEW] = (f.level > QFEW_LEVEL);
      // ready is a flop, so predict next fifo count and mode
      lvl_next = LVL_W'(f.level + LVL_W'(f.in_valid && f.in_ready)
                 - LVL_W'(f.out_ready && f.out_valid));
      rdy_d = cmd_d[CMD_WRITE] && (lvl_next != LVL_W'(FIFO_DEPTH));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         cmd_q <= RST_CMD;
         sh_q <= '0;
         acc_q <= '0;
         left_q <= '0;
         fill_q <= '0;
         x_q <= '0;
         y_q <= '0;
         col_q <= '0;
         row_q <= '0;
         w_q <= '0;
         h_q <= '0;
         x0_q <= '0;
         last_q <= 1'b0;
         vx_q <= '0;
         vy_q <= '0;
         wd_q <= '0;
         wm_q <= '0;
         we_q <= 1'b0;
         re_q <= 1'b0;
         rd_q <= '0;
         status_q <= RST_STATUS;
         rdy_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cmd_q <= cmd_d;
         sh_q <= sh_d;
         acc_q <= acc_d;
         left_q <= left_d;
         fill_q <= fill_d;
         x_q <= x_d;
         y_q <= y_d;
         col_q <= col_d;
         row_q <= row_d;
         w_q <= w_d;
         h_q <= h_d;
         x0_q <= x0_d;
         last_q <= last_d;
         vx_q <= vx_d;
         vy_q <= vy_d;
         wd_q <= wd_d;
         wm_q <= wm_d;
         we_q <= we_d;
         re_q <= re_d;
         rd_q <= rd_d;
         status_q <= status_d;
         rdy_q <= rdy_d;
      end
   end

   assign vm_x = vx_q;
   assign vm_y = vy_q;
   assign vm_we = we_q;
   assign vm_wdata = wd_q;
   assign vm_wmask = wm_q;
   assign vm_re = re_q;
   assign pixel_data_port_rd = rd_q;
   assign gp_status = status_q;
   assign pixel_data_port_wr_ready = rdy_q;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_cmd_starts_engine: assert property (cmd_ok |=> state_q != ST_IDLE)
      else $error("accepted command did not start");
   a_avail_bit_follows: assert property (
      gp_status[STAT_AVAIL] == $past(read_q && f.out_valid))
      else $error("data available bit wrong");
   a_qfew_bit_level: assert property (
      (f.level > QFEW_LEVEL) |=> gp_status[STAT_QFEW])
      else $error("few slots bit not set");
   a_write_mask_used: assert property (
      vm_we |-> vm_wmask == $past(plane_write_mask))
      else $error("write mask not applied");
   a_fore_only_colour: assert property (
      (state_q == ST_WPIX && multi_control[MC_SEL_HI:MC_SEL_LO] == MC_SEL_FORE
       && fore_mix_select[MIX_SRC_HI:MIX_SRC_LO] == SRC_FORE
       && fore_mix_select[3:0] == MIX_NEW) |=> vm_wdata == $past(fore_colour))
      else $error("fore mix colour not written");
   a_host_zero_back: assert property (
      (state_q == ST_WPIX && across && !sh_q[15]
       && multi_control[MC_SEL_HI:MC_SEL_LO] == MC_SEL_HOST
       && back_mix_select[MIX_SRC_HI:MIX_SRC_LO] == SRC_BACK
       && back_mix_select[3:0] == MIX_NEW) |=> vm_wdata == $past(back_colour))
      else $error("zero bit did not take back colour");
   a_read_mask_and: assert property (
      (state_q == ST_RWAIT && vm_rvalid && across
       && (vm_rdata & plane_read_mask) != plane_read_mask) |=> !acc_q[0])
      else $error("masked plane and failed");
   a_row_end_push: assert property (
      (state_q == ST_RWAIT && vm_rvalid && row_end) |=> state_q == ST_RPUSH)
      else $error("row end did not flush word");
   a_swap_order: assert property (
      (state_q == ST_FETCH && f.out_valid && bus16 && swap)
      |=> sh_q == {$past(f.out_data[7:0]), $past(f.out_data[15:8])})
      else $error("byte swap order wrong");
   a_col_bounded: assert property (col_q <= w_q)
      else $error("column past width");

   c_write_done: cover property (state_q == ST_WPIX && last_px);
   c_read_done: cover property (state_q == ST_RPUSH && last_q && f.in_ready);
   c_mono_write: cover property (state_q == ST_WPIX && across && sel_bg);
   c_fifo_full: cover property (!f.in_ready);
endmodule // gitp_top

// ---- bench/gitp_vmem.sv ----
`timescale 1ns/100ps
// ****
// video memory stand-in
// ****
module gitp_vmem (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [11:0] vm_x,
   input wire logic [11:0] vm_y,
   input wire logic vm_we,
   input wire logic [7:0] vm_wdata,
   input wire logic [7:0] vm_wmask,
   input wire logic vm_re,
   output logic vm_rvalid,
   output logic [7:0] vm_rdata
);
   logic [15:0] mem [logic [23:0]];
   int writes;
   int reads;
   logic slow;
   logic [7:0] d;
   task clear;
      mem.delete();
      writes = 0;
      reads = 0;
   endtask
   initial begin
      vm_rvalid = 1'b0;
      vm_rdata = 8'h00;
      slow = 1'b0;
   end
   always @(posedge clk) begin
      if (rst_n && vm_we) begin
         mem[{vm_y, vm_x}] = {vm_wmask, vm_wdata};
         writes++;
      end
   end
   // every other read answers late
   always @(posedge clk) begin
      if (rst_n && vm_re) begin
         d = {vm_y[3:0], vm_x[3:0]};
         reads++;
         slow = ~slow;
         repeat (slow ? 3 : 1) @(negedge clk);
         vm_rvalid = 1'b1;
         vm_rdata = d;
         @(negedge clk);
         vm_rvalid = 1'b0;
         // released bus shows junk, not the old value
         vm_rdata = ~d;
      end
   end
endmodule // gitp_vmem

// ---- bench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
   import gitp_pkg::*;
   logic clk, rst_n, cmd_wr, fp, wr_v, wr_rdy, rd_stb, vm_we, vm_re, vm_rv;
   logic [15:0] cmd, mc, fmix, bmix, wr_d, rd_d, stat, m;
   logic [7:0] fcol, bcol, wm, rm, vm_wd, vm_wm, vm_rd;
   logic [11:0] sx, sy, wm1, hm1, vm_x, vm_y;
   int errors, samples_checked, cycles;

   gitp_top gitp_top_inst (.clk(clk), .rst_n(rst_n), .cmd_word(cmd), .cmd_wr(cmd_wr),
      .multi_control(mc), .fore_mix_select(fmix), .back_mix_select(bmix),
      .fore_colour(fcol), .back_colour(bcol), .plane_write_mask(wm), .plane_read_mask(rm),
      .four_plane(fp), .start_x(sx), .start_y(sy), .rect_width_minus_one(wm1),
      .rect_height_minus_one(hm1), .pixel_data_port_wr(wr_d),
      .pixel_data_port_wr_valid(wr_v), .pixel_data_port_wr_ready(wr_rdy),
      .pixel_data_port_rd_strobe(rd_stb), .pixel_data_port_rd(rd_d), .gp_status(stat),
      .vm_x(vm_x), .vm_y(vm_y), .vm_we(vm_we), .vm_wdata(vm_wd), .vm_wmask(vm_wm),
      .vm_re(vm_re), .vm_rvalid(vm_rv), .vm_rdata(vm_rd));
   gitp_vmem gitp_vmem_inst (.clk(clk), .rst_n(rst_n), .vm_x(vm_x), .vm_y(vm_y),
      .vm_we(vm_we), .vm_wdata(vm_wd), .vm_wmask(vm_wm), .vm_re(vm_re),
      .vm_rvalid(vm_rv), .vm_rdata(vm_rd));

   // ****
   // helpers
   // ****
   task check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task cfg(input logic [15:0] a, b, c, input logic [7:0] d, e, f, input logic [11:0] x, y);
      mc = a;
      fmix = b;
      bmix = c;
      fcol = d;
      bcol = e;
      wm = f;
      sx = x;
      sy = y;
   endtask
   task run(input logic [15:0] c, input logic [11:0] w, input logic [11:0] h);
      cmd = c;
      wm1 = w;
      hm1 = h;
      cmd_wr = 1'b1;
      @(negedge clk);
      cmd_wr = 1'b0;
      check(stat[STAT_BUSY], 1'b0);
      @(negedge clk);
      check(stat[STAT_BUSY], 1'b1);
   endtask
   // valid stays up between words; caller drops it
   task push(input logic [15:0] w);
      wr_d = w;
      wr_v = 1'b1;
      while (wr_rdy !== 1'b1) @(negedge clk);
      @(negedge clk);
   endtask
   task idle;
      while (stat[STAT_BUSY] !== 1'b0) @(negedge clk);
   endtask
   task rd(input logic [15:0] e);
      while (stat[STAT_AVAIL] !== 1'b1) @(negedge clk);
      rd_stb = 1'b1;
      @(negedge clk);
      rd_stb = 1'b0;
      @(negedge clk);
      check(rd_d, e);
   endtask
   task mem_is(input int x, input int y, input logic [15:0] e, input logic [15:0] k);
      check(gitp_vmem_inst.mem[{12'(y), 12'(x)}] & k, e);
   endtask

   // ****
   // scenarios
   // ****
   task s_fill;
      gitp_vmem_inst.clear;
      cfg(16'ha080, 16'h0027, 16'h0007, 8'h04, 8'h5a, 8'hff, 12'd30, 12'd40);
      for (int r = 0; r < 8; r++) push(16'h9b00 ^ 16'(r << 12));
      wr_v = 1'b0;
      check(wr_rdy, 1'b0);
      @(negedge clk);
      check(stat[STAT_QFEW], 1'b1);
      cmd = 16'hc073;
      cmd_wr = 1'b1;
      @(negedge clk);
      cmd_wr = 1'b0;
      repeat (2) @(negedge clk);
      check(stat[STAT_BUSY], 1'b0);
      run(16'h4373, 12'd4, 12'd7);
      cmd = 16'h4372;
      cmd_wr = 1'b1;
      @(negedge clk);
      cmd_wr = 1'b0;
      idle;
      check(gitp_vmem_inst.writes, 40);
      check(gitp_vmem_inst.reads, 0);
      for (int r = 0; r < 8; r++) begin
         m = 16'h9b00 ^ 16'(r << 12);
         for (int i = 0; i < 5; i++) begin
            mem_is(30 + i, 40 + r, {8'hff, m[15 - i] ? 8'h04 : 8'h5a}, 16'hffff);
         end
      end
   endtask
   task s_wr;
      gitp_vmem_inst.clear;
      cfg(16'ha000, 16'h0047, 16'h0007, 8'h00, 8'h00, 8'hf0, 12'd10, 12'd20);
      run(16'h5371, 12'd2, 12'd1);
      for (int r = 0; r < 2; r++) begin
         push({8'h31 + 8'(r * 8), 8'h30 + 8'(r * 8)});
         push({8'hee, 8'h32 + 8'(r * 8)});
      end
      wr_v = 1'b0;
      idle;
      check(gitp_vmem_inst.writes, 6);
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 3; i++) begin
            mem_is(10 + i, 20 + r, {8'hf0, 8'h30 + 8'(r * 8 + i)}, 16'hffff);
         end
      end
   endtask
   task s_wr_more;
      gitp_vmem_inst.clear;
      cfg(16'ha080, 16'h0002, 16'h0001, 8'h04, 8'h5a, 8'h04, 12'd0, 12'd0);
      run(16'h4173, 12'd9, 12'd0);
      push(16'hccb7);
      push(16'h3380);
      wr_v = 1'b0;
      idle;
      check(gitp_vmem_inst.writes, 10);
      m = 16'hb780;
      for (int i = 0; i < 10; i++) mem_is(i, 0, {8'h04, m[15 - i] ? 8'hff : 8'h00}, 16'hffff);
      gitp_vmem_inst.clear;
      fp = 1'b1;
      cfg(16'ha000, 16'h0047, 16'h0007, 8'h00, 8'h00, 8'hff, 12'd0, 12'd1);
      run(16'h4371, 12'd4, 12'd0);
      push(16'h1234);
      push(16'h5eee);
      wr_v = 1'b0;
      idle;
      check(gitp_vmem_inst.writes, 5);
      for (int i = 0; i < 5; i++) mem_is(i, 1, 16'(i + 1), 16'h000f);
      gitp_vmem_inst.clear;
      cfg(16'ha000, 16'h0027, 16'h0007, 8'h2c, 8'h00, 8'hff, 12'd7, 12'd3);
      run(16'h4371, 12'd1, 12'd0);
      push(16'h0000);
      wr_v = 1'b0;
      idle;
      check(gitp_vmem_inst.writes, 2);
      for (int i = 0; i < 2; i++) mem_is(7 + i, 3, 16'hff2c, 16'hffff);
   endtask
   task s_rd;
      cfg(16'ha000, 16'h0047, 16'h0007, 8'h00, 8'h00, 8'hff, 12'd1, 12'd2);
      run(16'h4370, 12'd2, 12'd0);
      check(wr_rdy, 1'b0);
      rd(16'h1230);
      idle;
      fp = 1'b0;
      cfg(16'ha000, 16'h0047, 16'h0007, 8'h00, 8'h00, 8'hff, 12'd4, 12'd6);
      run(16'h4370, 12'd2, 12'd1);
      for (int r = 0; r < 2; r++) begin
         rd({8'h64 + 8'(r * 16), 8'h65 + 8'(r * 16)});
         rd({8'h66 + 8'(r * 16), 8'h00});
      end
      idle;
      rm = 8'h03;
      cfg(16'ha0c0, 16'h0002, 16'h0001, 8'h00, 8'h00, 8'hff, 12'd4, 12'd3);
      run(16'h4372, 12'd4, 12'd0);
      rd(16'h1000);
      idle;
   endtask

   // ****
   // clock, limit, main
   // ****
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         final_report;
      end
   end
   initial begin
      rst_n = 1'b0;
      cmd_wr = 1'b0;
      fp = 1'b0;
      wr_v = 1'b0;
      rd_stb = 1'b0;
      cmd = 16'h0000;
      wr_d = 16'h0000;
      rm = 8'h00;
      wm1 = 12'h000;
      hm1 = 12'h000;
      cfg(16'ha000, 16'h0007, 16'h0007, 8'h00, 8'h00, 8'hff, 12'd0, 12'd0);
      repeat (3) @(negedge clk);
      check(stat, RST_STATUS);
      check(wr_rdy, 1'b1);
      rst_n = 1'b1;
      s_fill;
      s_wr;
      s_wr_more;
      s_rd;
      final_report;
   end
endmodule // testbench
